// File: hdl/dki_pkg.sv
// Purpose: Shared constants and types for the key and I/O process image block
// Assumes: 32-bit AHB-Lite data, one word per register
// Notes:   Image layout is fixed; nothing here is meant to be changed per build

package dki_pkg;

  // Image geometry
  localparam int KEY_COUNT    = 32;
  localparam int EXT_IN_COUNT = 16;
  localparam int EXT_OUT_CNT  = 16;
  localparam int IMAGE_BYTES  = 6;

  // Register byte offsets
  localparam int         ADDR_W          = 12;
  localparam logic [11:0] OFS_IN_IMAGE_LO = 12'h000;
  localparam logic [11:0] OFS_IN_IMAGE_HI = 12'h004;
  localparam logic [11:0] OFS_OUT_IMAGE   = 12'h008;
  localparam logic [11:0] OFS_STATUS      = 12'h00c;

  // Status field positions
  localparam int STAT_SENDING_BIT = 0;
  localparam int STAT_KEYS_VALID  = 1;

  // Reset values
  localparam logic [15:0] OUT_IMAGE_RESET = 16'h0000;
  localparam logic [31:0] KEY_RESET       = 32'h0000_0000;

  // AHB transfer type and response codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Serial key port as seen on the internal connector
  typedef struct packed {
    logic key_shift_clock;
    logic key_data;
    logic key_latch;
  } dki_key_port_t;

endpackage

// File: hdl/dki_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pins
// Assumes: Each bit is an independent level
// Notes:   The first stage feeds only the second stage

`timescale 1ns/1ps

module dki_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  // Refuse a zero-width group
  if (W < 1) begin : g_bad_width
    $error("dki_sync: W must be at least 1");
  end

  // One pair of flops per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic stage1;
    always_ff @(posedge clk) begin
      if (rst) begin
        stage1   <= 1'b0;
        d_out[i] <= 1'b0;
      end else begin
        stage1   <= d_in[i];
        d_out[i] <= stage1;
      end
    end
  end

endmodule // dki_sync

// File: hdl/dki_image.sv
// Purpose: Fieldbus process image of a key and I/O slave, reached over AHB-Lite
// Assumes: Single whole-word transfers; TX_ACTIVE comes from the protocol engine on CLK
// Notes:   Zero wait states; unmapped reads return zero, unmapped writes are dropped
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.

`timescale 1ns/1ps

module dki_image (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // AHB-Lite slave
  input  wire logic                  HSEL,
  input  wire logic [31:0]           HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic      [31:0]           HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  // Keyboard controller serial port (asynchronous)
  input  wire dki_pkg::dki_key_port_t KEY_PORT,
  // External I/O
  input  wire logic [15:0]           EXT_IN,
  output logic      [15:0]           EXT_OUT,
  // Protocol engine transmit state and send indicator
  input  wire logic                  TX_ACTIVE,
  output logic                       REQ_TO_SEND
);

  // Synchronised pins
  logic [2:0]  key_s;
  logic [15:0] ext_s;
  logic        shift_s;
  logic        data_s;
  logic        latch_s;

  dki_sync #(.W(3)) u_key_sync (
    .clk   (CLK),
    .rst   (RST),
    .d_in  ({KEY_PORT.key_shift_clock, KEY_PORT.key_data, KEY_PORT.key_latch}),
    .d_out (key_s)
  );

  dki_sync #(.W(16)) u_ext_sync (
    .clk   (CLK),
    .rst   (RST),
    .d_in  (EXT_IN),
    .d_out (ext_s)
  );

  assign shift_s = key_s[2];
  assign data_s  = key_s[1];
  assign latch_s = key_s[0];

  // Key capture state
  logic        shift_d;
  logic        latch_d;
  logic [31:0] shreg;
  logic [31:0] key_state;
  logic        keys_valid;
  logic        shift_rise;
  logic        latch_rise;
  logic [31:0] next_shreg;
  logic [31:0] next_key_state;
  logic        next_keys_valid;

  assign shift_rise = shift_s & ~shift_d;
  assign latch_rise = latch_s & ~latch_d;

  // Shift in first bit as key 1, commit whole package at latch
  always_comb begin
    next_shreg      = shreg;
    next_key_state  = key_state;
    next_keys_valid = keys_valid;
    if (shift_rise) begin
      next_shreg = {data_s, shreg[31:1]};
    end
    if (latch_rise) begin
      next_key_state  = shreg;
      next_keys_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      shift_d    <= 1'b0;
      latch_d    <= 1'b0;
      shreg      <= dki_pkg::KEY_RESET;
      key_state  <= dki_pkg::KEY_RESET;
      keys_valid <= 1'b0;
    end else begin
      shift_d    <= shift_s;
      latch_d    <= latch_s;
      shreg      <= next_shreg;
      key_state  <= next_key_state;
      keys_valid <= next_keys_valid;
    end
  end

  // Fixed six-byte input image
  logic [47:0] in_image;
  assign in_image = {key_state[31:16], ext_s, key_state[15:0]};

  // Bus slave state
  logic [11:0] wr_addr;
  logic        wr_pend;
  logic [15:0] out_image;
  logic [31:0] rd_data;
  logic        send;
  logic        addr_ok;
  logic [11:0] a_ofs;
  logic [11:0] next_wr_addr;
  logic        next_wr_pend;
  logic [15:0] next_out_image;
  logic [31:0] next_rd_data;

  assign addr_ok = HSEL & HREADY & (HTRANS == dki_pkg::HTRANS_NONSEQ);
  assign a_ofs   = HADDR[11:0];

  // Address phase decode, data phase write
  always_comb begin
    next_wr_addr   = wr_addr;
    next_wr_pend   = 1'b0;
    next_out_image = out_image;
    next_rd_data   = rd_data;
    if (wr_pend && wr_addr == dki_pkg::OFS_OUT_IMAGE) begin
      next_out_image = HWDATA[15:0];
    end
    if (addr_ok && HWRITE) begin
      next_wr_addr = a_ofs;
      next_wr_pend = 1'b1;
    end
    if (addr_ok && !HWRITE) begin
      case (a_ofs)
        dki_pkg::OFS_IN_IMAGE_LO: next_rd_data = in_image[31:0];
        dki_pkg::OFS_IN_IMAGE_HI: next_rd_data = {16'h0000, in_image[47:32]};
        dki_pkg::OFS_OUT_IMAGE:   next_rd_data = {16'h0000, next_out_image};
        dki_pkg::OFS_STATUS:      next_rd_data = {30'h0, keys_valid, send};
        default:                  next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_addr   <= 12'h000;
      wr_pend   <= 1'b0;
      out_image <= dki_pkg::OUT_IMAGE_RESET;
      rd_data   <= 32'h0000_0000;
      send      <= 1'b0;
    end else begin
      wr_addr   <= next_wr_addr;
      wr_pend   <= next_wr_pend;
      out_image <= next_out_image;
      rd_data   <= next_rd_data;
      send      <= TX_ACTIVE;
    end
  end

  // HRDATA, EXT_OUT and REQ_TO_SEND straight from flops; HREADYOUT and HRESP constant
  assign HRDATA      = rd_data;
  assign HREADYOUT   = 1'b1;
  assign HRESP       = dki_pkg::HRESP_OKAY;
  assign EXT_OUT     = out_image;
  assign REQ_TO_SEND = send;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_latch;
    latch_rise;
  endsequence

  sequence s_rd_lo;
    addr_ok && !HWRITE && a_ofs == dki_pkg::OFS_IN_IMAGE_LO;
  endsequence

  sequence s_rd_hi;
    addr_ok && !HWRITE && a_ofs == dki_pkg::OFS_IN_IMAGE_HI;
  endsequence

  sequence s_wr_out;
    addr_ok && HWRITE && a_ofs == dki_pkg::OFS_OUT_IMAGE;
  endsequence

  a_key_commit: assert property (s_latch |=> key_state == $past(shreg))
    else $error("key image not loaded from shift register at latch");

  a_keys_hold: assert property (!latch_rise |=> $stable(key_state))
    else $error("key image changed without latch");

  a_shift_order: assert property (shift_rise && !latch_rise |=> shreg == {$past(data_s), $past(shreg[31:1])})
    else $error("serial key bit shifted into wrong position");

  a_image_low: assert property (s_rd_lo |=> HRDATA == {$past(ext_s), $past(key_state[15:0])})
    else $error("input bytes 0 to 3 misplaced");

  a_image_ext: assert property (s_rd_lo |=> HRDATA[23:16] == $past(ext_s[7:0]) && HRDATA[31:24] == $past(ext_s[15:8]))
    else $error("external inputs not in bytes 2 and 3");

  a_image_high: assert property (s_rd_hi |=> HRDATA == {16'h0000, $past(key_state[31:16])})
    else $error("input bytes 4 and 5 misplaced");

  a_out_write: assert property (s_wr_out ##1 1'b1 |=> EXT_OUT == $past(HWDATA[15:0]))
    else $error("output image not driven from written data");

  a_send_follow: assert property (TX_ACTIVE |=> REQ_TO_SEND ##1 (REQ_TO_SEND == $past(TX_ACTIVE)))
    else $error("send indicator does not follow transmit state");

endmodule // dki_image

// File: verif/dki_kbd_model.sv
// Purpose: Keyboard controller model, serial key source
// Assumes: Each shift clock and latch level held 3 CLK cycles, each data bit 6
// Notes:   Idle data line shows inverse of last bit
`timescale 1ns/1ps
module dki_kbd_model (
  input  wire logic              clk,
  input  wire logic              start,
  input  wire logic [31:0]       keys,
  output dki_pkg::dki_key_port_t port,
  output logic                   busy
);
  logic [31:0] k;

  // Shifts key 1 first, then strobes the latch
  initial begin
    port = '0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        k = keys;
        busy <= 1'b1;
        for (int i = 0; i < 32; i++) begin
          port.key_data <= k[i];
          repeat (3) @(posedge clk);
          port.key_shift_clock <= 1'b1;
          repeat (3) @(posedge clk);
          port.key_shift_clock <= 1'b0;
        end
        repeat (3) @(posedge clk);
        port.key_latch <= 1'b1;
        repeat (3) @(posedge clk);
        port.key_latch <= 1'b0;
        port.key_data  <= ~k[31];
        busy           <= 1'b0;
      end
    end
  end
endmodule // dki_kbd_model

// File: verif/test_direct_key_io_image.sv
// Purpose: Self-checking bench for the process image block
// Assumes: One AHB slave, zero wait states
// Notes:   Reads queue their expected word for the monitor
`timescale 1ns/1ps
module test_direct_key_io_image;
  logic                   CLK, RST, HWRITE, TX_ACTIVE, HREADYOUT, HRESP, REQ_TO_SEND;
  logic                   kb_start, kb_busy, dphase, last_tx;
  logic [1:0]             HTRANS;
  logic [31:0]            HADDR, HWDATA, HRDATA, kb_keys, cur;
  logic [15:0]            EXT_IN, EXT_OUT, ov;
  dki_pkg::dki_key_port_t kp;
  logic [31:0]            q[$];
  int                     fail_count, n_compared;
  integer                 seed;

  dki_image dut (.CLK(CLK), .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .KEY_PORT(kp), .EXT_IN(EXT_IN),
    .EXT_OUT(EXT_OUT), .TX_ACTIVE(TX_ACTIVE), .REQ_TO_SEND(REQ_TO_SEND));
  dki_kbd_model kbd (.clk(CLK), .start(kb_start), .keys(kb_keys), .port(kp), .busy(kb_busy));

  // Clock
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One single transfer, address phase then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    HTRANS <= dki_pkg::HTRANS_NONSEQ;
    HADDR  <= {20'h0, a};
    HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    dphase <= ~w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    dphase <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Both image words against committed keys and live inputs
  task automatic img;
    rd(dki_pkg::OFS_IN_IMAGE_LO, {EXT_IN, cur[15:0]});
    rd(dki_pkg::OFS_IN_IMAGE_HI, {16'h0, cur[31:16]});
  endtask

  // Sends a frame; image must stay old until the latch
  task automatic frame(input logic [31:0] k);
    kb_keys  <= k;
    kb_start <= 1'b1;
    @(posedge CLK);
    kb_start <= 1'b0;
    // Most bits already shifted, latch still ahead
    repeat (150) @(posedge CLK);
    img();
    while (kb_busy) @(posedge CLK);
    repeat (6) @(posedge CLK);
    cur = k;
  endtask

  // Monitor takes the oldest note at each read data phase
  always @(posedge CLK) begin
    if (dphase && HREADYOUT) begin
      chk("HRDATA", HRDATA, q.pop_front());
      chk("HRESP", {31'h0, HRESP}, {31'h0, dki_pkg::HRESP_OKAY});
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    close_out();
  end

  // Main sequence
  initial begin
    {RST, HWRITE, TX_ACTIVE, kb_start, dphase} = 5'h10;
    {HTRANS, HADDR, HWDATA, kb_keys, cur, EXT_IN} = '0;
    seed = 32'h75cd;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rd(dki_pkg::OFS_STATUS, 32'h0);
    chk("EXT_OUT", {16'h0, EXT_OUT}, 32'h0);
    for (int n = 0; n < 2; n++) begin
      EXT_IN <= 16'($random(seed));
      frame($random(seed));
      img();
    end
    rd(dki_pkg::OFS_STATUS, 32'h2);
    $display("keys done");
    for (int n = 0; n < 3; n++) begin
      ov = 16'($random(seed));
      bus(1'b1, dki_pkg::OFS_OUT_IMAGE, {16'h0, ov});
      rd(dki_pkg::OFS_OUT_IMAGE, {16'h0, ov});
      chk("EXT_OUT", {16'h0, EXT_OUT}, {16'h0, ov});
    end
    bus(1'b1, dki_pkg::OFS_IN_IMAGE_HI, 32'hffff_ffff);
    bus(1'b1, 12'h010, 32'h0);
    img();
    rd(12'h010, 32'h0);
    rd(dki_pkg::OFS_OUT_IMAGE, {16'h0, ov});
    $display("bus done");
    last_tx = TX_ACTIVE;
    for (int n = 0; n < 20; n++) begin
      @(posedge CLK);
      chk("REQ_TO_SEND", {31'h0, REQ_TO_SEND}, {31'h0, last_tx});
      last_tx = TX_ACTIVE;
      TX_ACTIVE <= 1'($random(seed));
    end
    TX_ACTIVE <= 1'b1;
    @(posedge CLK);
    rd(dki_pkg::OFS_STATUS, 32'h3);
    repeat (2) @(posedge CLK);
    $display("send done");
    // Mid-run reset clears outputs, keys and status
    TX_ACTIVE <= 1'b0;
    @(posedge CLK);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    cur = 32'h0;
    rd(dki_pkg::OFS_STATUS, 32'h0);
    chk("EXT_OUT", {16'h0, EXT_OUT}, 32'h0);
    img();
    $display("reset done");
    close_out();
  end
endmodule // test_direct_key_io_image
